// ==== pdhf_pkg.sv ====
// constants shared by the path framer and its elastic store
package pdhf_pkg;
	// frame geometry
	localparam int unsigned FRAME_BITS = 2928;
	localparam logic [11:0] FRAME_LAST = 12'(FRAME_BITS - 1);
	localparam logic [11:0] OVH_BITS = 12'h010;
	localparam logic [11:0] FAW_BITS = 12'h00c;
	localparam logic [11:0] RDB_POS = 12'h00c;
	localparam logic [11:0] NUB_POS = 12'h00d;
	localparam logic [11:0] FAW_PATTERN = 12'hfa0;
	localparam logic [9:0] UNIT_BITS = 10'h2d8;
	// tributary unit layout: first set, then five control sets of 122 bits
	localparam logic [9:0] UNIT_SET1_BITS = 10'h076;
	localparam logic [9:0] UNIT_SET_BITS = 10'h07a;
	localparam logic [9:0] UNIT_JBIT = 10'h25f;
	// elastic store
	localparam int unsigned STORE_AW = 5;
	localparam logic [5:0] STORE_HALF = 6'h10;
	// remote defect handling
	localparam int unsigned RDB_TIME_US = 900;
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned RDB_TIME_CYC = RDB_TIME_US * CLK_MHZ;
	localparam logic [2:0] RDB_CONFIRM = 3'h5;
	// register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] ERRC_OFS = 8'h08;
	localparam logic [7:0] NUB_OFS = 8'h0c;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [2:0] NUB_RESET = 3'h0;
	localparam int unsigned CTRL_ACT = 0;
	localparam int unsigned CTRL_MON = 1;
	localparam int unsigned CTRL_RDEN = 2;
	localparam int unsigned CTRL_SFEN = 3;
	localparam int unsigned STAT_FILL = 8;
	localparam int unsigned NUB_RX = 4;
	// role of a bit inside a tributary unit
	typedef enum logic [1:0] {PDHF_DATA, PDHF_CTRL, PDHF_JUST} pdhf_role_t;
endpackage

// ==== pdhf_store.sv ====
// bit-wide elastic store memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pdhf_store (
	input wire logic core_clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic ce, // clock enable
	input wire logic wr_en, // write strobe
	input wire logic [pdhf_pkg::STORE_AW-1:0] wr_addr, // write address
	input wire logic wr_data, // write bit
	input wire logic [pdhf_pkg::STORE_AW-1:0] rd_addr, // read address
	output logic rd_data // registered read bit
);
	logic mem [0:(1<<pdhf_pkg::STORE_AW)-1];

	// memory write
	always_ff @(posedge core_clk)
	begin
		if (ce && wr_en)
			mem[wr_addr] <= wr_data;
	end

	// registered read every enabled cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rd_data <= 1'b0;
		else if (ce)
			rd_data <= mem[rd_addr];
	end
endmodule // pdhf_store
`default_nettype wire

// ==== pdhf_path_framer.sv ====
// path framer: overhead source, overhead sink and one tributary mapper
// Notes on behaviour
// R1: line frames are 2928 bits, 16 overhead first, frame start marked.
// R2: overhead is 12 alignment bits, one remote defect bit, three national bits.
// R3: national-use bits pass through untouched as user information.
// R4: payload bit-interleaves four tributary units of 728 bits each.
// R5: source writes alignment word and defect bit into first 16 positions.
// R6: outgoing defect bit follows the request within 900 us both ways.
// R7: alignment pattern 111110100000 goes into every frame.
// R8: sink takes position row 4 column 1 as remote receiver status.
// R9: sink detects remote defect from received bit and holds a flag.
// R10: fault reports gated by defect, monitored state and report enable.
// R11: any alignment bit mismatch flags an errored block, counted.
// R12: mapper places one 34 Mbit/s stream into its 728-bit unit.
// R13: store is written on the tributary's own clock.
// R14: store read on aggregate clock, gated by position and justification.
// R15: positive justification skips one read, opportunity bit carries no data.
// R16: store depth and control give no errors within plus-minus 20 ppm.
// R17: five control bits per frame placed in their unit positions.
// R18: control bits all one for justification, all zero for data.
// R19: one static unit index 1 to 4 per mapper.
// R20: only permitted mappers may reach the aggregate, others refused.
// R21: mapper drives its unit only while activated, else leaves aggregate.
// R22: server fail drives trail fail out and remote defect request.
// R23: position counters reset to zero on every frame start.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pdhf_path_framer #(
	parameter int unsigned TRIB_INDEX = 1, // unit served, 1 to 4
	parameter int unsigned RDB_LIMIT = pdhf_pkg::RDB_TIME_CYC // defect bit deadline
) (
	input wire logic core_clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic ce, // clock enable, freezes state when low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic tx_bit_clk, // aggregate bit clock
	input wire logic timing_frame_start, // source frame start
	input wire logic aggregate_in, // aggregate from other mappers
	input wire logic access_permit, // arbitration grant for this mapper
	input wire logic trib_clk, // tributary clock
	input wire logic trib_data, // tributary data
	output logic line_data, // outgoing line bit
	output logic line_frame_start, // marks frame bit 0
	output logic line_bit_strobe, // one pulse per line bit
	input wire logic rx_bit_clk, // received bit clock
	input wire logic rx_frame_start, // received frame start
	input wire logic rx_data, // received line bit
	input wire logic server_signal_fail_in, // server fail, same clock
	output logic trail_signal_fail_out, // trail fail
	output logic remote_defect_request, // request toward source
	output logic remote_defect_detected, // held defect flag
	output logic remote_defect_fault_report, // gated defect report
	output logic server_fail_fault_report, // gated server fail report
	output logic near_block_errored, // errored block pulse
	output logic [2:0] national_use_bits // received user bits
);
	localparam logic [1:0] MY_SLOT = 2'(TRIB_INDEX - 1); // [R19]
	localparam int unsigned NIN = 8;

	// bit role inside a tributary unit
	function automatic pdhf_pkg::pdhf_role_t unit_role(input logic [9:0] k);
		logic [9:0] rel;
		rel = k - pdhf_pkg::UNIT_SET1_BITS;
		unit_role = pdhf_pkg::PDHF_DATA;
		if (k == pdhf_pkg::UNIT_JBIT)
			unit_role = pdhf_pkg::PDHF_JUST;
		else if (k >= pdhf_pkg::UNIT_SET1_BITS && (rel % pdhf_pkg::UNIT_SET_BITS) == 10'h000)
			unit_role = pdhf_pkg::PDHF_CTRL;
	endfunction

	// next frame position
	function automatic logic [11:0] next_pos(input logic fs, input logic [11:0] p);
		if (fs || p == pdhf_pkg::FRAME_LAST)
			next_pos = 12'h000;
		else
			next_pos = p + 12'h001;
	endfunction

	// two-stage synchronisers for all link pins
	logic [NIN-1:0] pin_meta_reg;
	logic [NIN-1:0] pin_sync_reg;
	logic [NIN-1:0] pin_raw;
	logic tx_clk_d_reg;
	logic rx_clk_d_reg;
	logic trib_clk_d_reg;
	assign pin_raw = {tx_bit_clk, timing_frame_start, aggregate_in, trib_clk, trib_data,
		rx_bit_clk, rx_frame_start, rx_data};
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			tx_clk_d_reg <= 1'b0;
			rx_clk_d_reg <= 1'b0;
			trib_clk_d_reg <= 1'b0;
		end
		else if (ce)
		begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			tx_clk_d_reg <= pin_sync_reg[7];
			rx_clk_d_reg <= pin_sync_reg[2];
			trib_clk_d_reg <= pin_sync_reg[4];
		end
	end

	logic tx_tick;
	logic rx_tick;
	logic trib_tick;
	assign tx_tick = ce && pin_sync_reg[7] && !tx_clk_d_reg;
	assign rx_tick = ce && pin_sync_reg[2] && !rx_clk_d_reg;
	assign trib_tick = ce && pin_sync_reg[4] && !trib_clk_d_reg;

	// registers
	logic [3:0] ctrl_reg;
	logic [2:0] nub_tx_reg;
	logic [15:0] errc_reg;
	logic ack_reg;
	logic bus_req;
	logic bus_wr;
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

	// elastic store pointers, one bit wider than the address
	logic [pdhf_pkg::STORE_AW:0] wr_ptr_reg;
	logic [pdhf_pkg::STORE_AW:0] rd_ptr_reg;
	logic [pdhf_pkg::STORE_AW:0] fill;
	logic store_bit;
	assign fill = wr_ptr_reg - rd_ptr_reg;

	// tributary write side, paced by its own clock edges
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			wr_ptr_reg <= '0;
		else if (trib_tick)
			wr_ptr_reg <= wr_ptr_reg + 1'b1; // [R13]
	end

	pdhf_store u_store (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.wr_en(trib_tick),
		.wr_addr(wr_ptr_reg[pdhf_pkg::STORE_AW-1:0]),
		.wr_data(pin_sync_reg[3]),
		.rd_addr(rd_ptr_reg[pdhf_pkg::STORE_AW-1:0]),
		.rd_data(store_bit)
	);

	// source position and this bit's place in the frame
	logic [11:0] tx_pos_reg;
	logic [11:0] tx_pos_next;
	logic [11:0] tx_pay;
	logic [9:0] tx_k;
	pdhf_pkg::pdhf_role_t tx_role;
	logic drive_unit;
	assign tx_pos_next = next_pos(pin_sync_reg[6], tx_pos_reg); // [R23]
	assign tx_pay = tx_pos_next - pdhf_pkg::OVH_BITS;
	assign tx_k = tx_pay[11:2]; // [R4]
	assign tx_role = unit_role(tx_k);
	assign drive_unit = ctrl_reg[pdhf_pkg::CTRL_ACT] && access_permit; // [R20] [R21]

	logic justify_reg;
	logic rdb_tx_reg;
	logic unit_bit;
	logic line_bit;
	// unit bit: data, control group or empty opportunity
	always_comb
	begin
		unit_bit = store_bit;
		if (tx_role == pdhf_pkg::PDHF_CTRL)
			unit_bit = justify_reg; // [R17] [R18]
		else if (tx_role == pdhf_pkg::PDHF_JUST && justify_reg)
			unit_bit = 1'b0; // [R15]
	end

	// line bit multiplexer: overhead, own unit, or pass-through
	always_comb
	begin
		line_bit = pin_sync_reg[5];
		if (tx_pos_next < pdhf_pkg::FAW_BITS)
			line_bit = pdhf_pkg::FAW_PATTERN[4'(11 - tx_pos_next[3:0])]; // [R7] [R5]
		else if (tx_pos_next == pdhf_pkg::RDB_POS)
			line_bit = rdb_tx_reg; // [R5] [R2]
		else if (tx_pos_next < pdhf_pkg::OVH_BITS)
			line_bit = nub_tx_reg[2'(tx_pos_next - pdhf_pkg::NUB_POS)]; // [R3]
		else if (tx_pay[1:0] == MY_SLOT && drive_unit)
			line_bit = unit_bit; // [R12] [R21]
	end

	// source position, frame start mark and line data
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_pos_reg <= pdhf_pkg::FRAME_LAST;
			line_data <= 1'b0;
			line_frame_start <= 1'b0;
			line_bit_strobe <= 1'b0;
		end
		else if (ce)
		begin
			line_bit_strobe <= tx_tick;
			if (tx_tick)
			begin
				tx_pos_reg <= tx_pos_next;
				line_data <= line_bit;
				line_frame_start <= (tx_pos_next == 12'h000); // [R1]
			end
		end
	end

	// read pointer advances on every data bit of own unit slot, whether or not the unit is driven
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rd_ptr_reg <= '0;
		else if (tx_tick && tx_pos_next >= pdhf_pkg::OVH_BITS && tx_pay[1:0] == MY_SLOT
			&& (tx_role == pdhf_pkg::PDHF_DATA
			|| (tx_role == pdhf_pkg::PDHF_JUST && !justify_reg)))
			rd_ptr_reg <= rd_ptr_reg + 1'b1; // [R14] [R15]
	end

	// per-frame justification decision and defect bit latch
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			justify_reg <= 1'b0;
			rdb_tx_reg <= 1'b0;
		end
		else if (tx_tick && tx_pos_next == 12'h000)
		begin
			justify_reg <= (fill < pdhf_pkg::STORE_HALF); // [R16]
			rdb_tx_reg <= remote_defect_request; // [R6]
		end
	end

	// sink position and overhead checks
	logic [11:0] rx_pos_reg;
	logic [11:0] rx_pos_next;
	logic faw_err_reg;
	logic [2:0] rdb_run_reg;
	logic nbe_pulse;
	assign rx_pos_next = next_pos(pin_sync_reg[1], rx_pos_reg); // [R23]
	assign nbe_pulse = rx_tick && rx_pos_next == pdhf_pkg::FAW_BITS - 12'h001
		&& (faw_err_reg || pin_sync_reg[0] != pdhf_pkg::FAW_PATTERN[0]); // [R11]
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_pos_reg <= pdhf_pkg::FRAME_LAST;
			faw_err_reg <= 1'b0;
			national_use_bits <= 3'h0;
		end
		else if (rx_tick)
		begin
			rx_pos_reg <= rx_pos_next;
			if (rx_pos_next == 12'h000)
				faw_err_reg <= pin_sync_reg[0] != pdhf_pkg::FAW_PATTERN[11]; // [R11]
			else if (rx_pos_next < pdhf_pkg::FAW_BITS)
				faw_err_reg <= faw_err_reg
					|| pin_sync_reg[0] != pdhf_pkg::FAW_PATTERN[4'(11 - rx_pos_next[3:0])];
			if (rx_pos_next >= pdhf_pkg::NUB_POS && rx_pos_next < pdhf_pkg::OVH_BITS)
				national_use_bits[2'(rx_pos_next - pdhf_pkg::NUB_POS)] <= pin_sync_reg[0]; // [R3]
		end
	end

	// remote defect detection with confirmation over frames
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			remote_defect_detected <= 1'b0;
			rdb_run_reg <= 3'h0;
		end
		else if (rx_tick && rx_pos_next == pdhf_pkg::RDB_POS) // [R8]
		begin
			if (pin_sync_reg[0] == remote_defect_detected)
				rdb_run_reg <= 3'h0;
			else if (rdb_run_reg + 3'h1 == pdhf_pkg::RDB_CONFIRM)
			begin
				remote_defect_detected <= pin_sync_reg[0]; // [R9]
				rdb_run_reg <= 3'h0;
			end
			else
				rdb_run_reg <= rdb_run_reg + 3'h1;
		end
	end

	// consequent actions and gated fault reports
	assign trail_signal_fail_out = server_signal_fail_in; // [R22]
	assign remote_defect_request = server_signal_fail_in; // [R22]
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			remote_defect_fault_report <= 1'b0;
			server_fail_fault_report <= 1'b0;
			near_block_errored <= 1'b0;
		end
		else if (ce)
		begin
			remote_defect_fault_report <= remote_defect_detected
				&& ctrl_reg[pdhf_pkg::CTRL_MON] && ctrl_reg[pdhf_pkg::CTRL_RDEN]; // [R10]
			server_fail_fault_report <= server_signal_fail_in
				&& ctrl_reg[pdhf_pkg::CTRL_MON] && ctrl_reg[pdhf_pkg::CTRL_SFEN]; // [R10]
			near_block_errored <= nbe_pulse; // [R11]
		end
	end

	// errored block counter, write clears, a coinciding error counts as one, saturates
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			errc_reg <= 16'h0000;
		else if (ce)
		begin
			if (nbe_pulse && bus_wr && wb_adr_i == pdhf_pkg::ERRC_OFS)
				errc_reg <= 16'h0001; // [R11]
			else if (bus_wr && wb_adr_i == pdhf_pkg::ERRC_OFS)
				errc_reg <= 16'h0000;
			else if (nbe_pulse && errc_reg != 16'hffff)
				errc_reg <= errc_reg + 16'h0001; // [R11]
		end
	end

	// control registers
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg <= pdhf_pkg::CTRL_RESET;
			nub_tx_reg <= pdhf_pkg::NUB_RESET;
		end
		else if (ce && bus_wr)
		begin
			if (wb_adr_i == pdhf_pkg::CTRL_OFS)
				ctrl_reg <= wb_dat_i[3:0];
			if (wb_adr_i == pdhf_pkg::NUB_OFS)
				nub_tx_reg <= wb_dat_i[2:0];
		end
	end

	// bus answer one cycle after the request, unmapped reads zero
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ack_reg <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else if (ce)
		begin
			ack_reg <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			case (wb_adr_i)
				pdhf_pkg::CTRL_OFS: wb_dat_o[3:0] <= ctrl_reg;
				pdhf_pkg::STAT_OFS: wb_dat_o <= {18'h0_0000,
					6'(fill), 4'h0, server_fail_fault_report,
					remote_defect_fault_report, rdb_tx_reg, remote_defect_detected};
				pdhf_pkg::ERRC_OFS: wb_dat_o[15:0] <= errc_reg;
				pdhf_pkg::NUB_OFS: wb_dat_o[6:0] <= {national_use_bits, 1'b0, nub_tx_reg};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
	assign wb_ack_o = ack_reg;

	// checks
	logic [16:0] rdb_wait_reg;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rdb_wait_reg <= '0;
		else if (rdb_tx_reg != remote_defect_request)
			rdb_wait_reg <= rdb_wait_reg + 17'h0_0001;
		else
			rdb_wait_reg <= '0;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_tx_bit(logic [11:0] p);
		tx_tick && tx_pos_next == p;
	endsequence

	a_faw_bit_out: assert property (tx_tick && tx_pos_next < pdhf_pkg::FAW_BITS |=>
		line_data == pdhf_pkg::FAW_PATTERN[4'(11 - tx_pos_reg[3:0])]) // [R7]
		else $error("alignment bit wrong");
	a_rdb_bit_out: assert property (s_tx_bit(pdhf_pkg::RDB_POS) |=> line_data == rdb_tx_reg) // [R5]
		else $error("defect bit wrong");
	a_rdb_deadline: assert property (rdb_wait_reg < 17'(RDB_LIMIT)) // [R6]
		else $error("defect bit late");
	a_frame_start_mark: assert property (s_tx_bit(12'h000) |=> line_frame_start) // [R1]
		else $error("frame start not marked");
	a_ctrl_group: assert property (tx_tick && tx_pos_next >= pdhf_pkg::OVH_BITS
		&& tx_pay[1:0] == MY_SLOT && drive_unit && tx_role == pdhf_pkg::PDHF_CTRL
		|=> line_data == justify_reg) // [R17]
		else $error("control bit wrong");
	a_unit_released: assert property (tx_tick && tx_pos_next >= pdhf_pkg::OVH_BITS
		&& !drive_unit |=> line_data == $past(pin_sync_reg[5])) // [R21]
		else $error("aggregate not passed");
	a_fault_gate: assert property (remote_defect_fault_report |->
		$past(remote_defect_detected) && $past(ctrl_reg[pdhf_pkg::CTRL_MON])) // [R10]
		else $error("defect report ungated");
	a_errored_count: assert property (nbe_pulse && !bus_wr && errc_reg != 16'hffff
		|=> near_block_errored && errc_reg == $past(errc_reg) + 16'h0001) // [R11]
		else $error("errored block lost");
	a_skip_read: assert property (tx_tick && tx_role == pdhf_pkg::PDHF_JUST && justify_reg
		|=> $stable(rd_ptr_reg)) // [R15]
		else $error("read on justification");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
endmodule // pdhf_path_framer
`default_nettype wire

// ==== pdhf_far_end.sv ====
// far-end line model: link bit clock, frame starts, received frames, capture
`timescale 1ns/1ps
`default_nettype none
module pdhf_far_end (
	input wire logic core_clk, // system clock
	input wire logic line_data, // outgoing line bit
	input wire logic line_frame_start, // outgoing frame marker
	input wire logic line_bit_strobe, // new line bit pulse
	output logic bit_clk, // shared link bit clock
	output logic tx_fs, // source frame start
	output logic rx_fs, // received frame start
	output logic rx_d // received line bit
);
	logic run;
	logic cap [0:4095];
	logic [11:0] cap_idx;
	// 160 ns link clock, paused while run is low, phase apart from core clock
	initial
	begin
		run = 1'b0;
		bit_clk = 1'b0;
		tx_fs = 1'b0;
		rx_fs = 1'b0;
		rx_d = 1'b0;
		#7;
		forever
		begin
			#80;
			if (run)
				bit_clk = ~bit_clk;
		end
	end
	// store outgoing bits by frame position
	always_ff @(posedge core_clk)
	begin
		if (line_bit_strobe)
		begin
			cap[line_frame_start ? 12'h000 : cap_idx] <= line_data;
			cap_idx <= line_frame_start ? 12'h001 : cap_idx + 12'h001;
		end
	end
	// one frame on both directions, lines change on the falling link edge
	task automatic send_frame(input int len, input logic rdb, input logic [2:0] nub,
		input logic [11:0] err);
		logic [15:0] ovh;
		ovh = {pdhf_pkg::FAW_PATTERN ^ err, rdb, nub[0], nub[1], nub[2]};
		run = 1'b1;
		for (int p = 0; p < len; p++)
		begin
			@(negedge bit_clk);
			tx_fs = (p == 0);
			rx_fs = (p == 0);
			rx_d = (p < 16) ? ovh[15-p] : ~rx_d; // payload toggles each bit
			@(posedge bit_clk);
		end
		run = 1'b0; // link clock stands still between frames
	endtask
endmodule // pdhf_far_end
`default_nettype wire

// ==== tb.sv ====
// self-checking testbench of the path framer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic aggregate_in, access_permit, trib_clk, trib_data, server_signal_fail_in, trib_run;
	logic bit_clk, tx_fs, rx_fs, rx_d, line_data, line_frame_start, line_bit_strobe;
	logic trail_signal_fail_out, remote_defect_request, remote_defect_detected;
	logic remote_defect_fault_report, server_fail_fault_report, near_block_errored;
	logic [2:0] national_use_bits;
	int err_count, tests_run, nbe_cnt, trib_div;
	pdhf_path_framer dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_bit_clk(bit_clk),
		.timing_frame_start(tx_fs), .aggregate_in(aggregate_in), .access_permit(access_permit),
		.trib_clk(trib_clk), .trib_data(trib_data), .line_data(line_data),
		.line_frame_start(line_frame_start), .line_bit_strobe(line_bit_strobe),
		.rx_bit_clk(bit_clk), .rx_frame_start(rx_fs), .rx_data(rx_d),
		.server_signal_fail_in(server_signal_fail_in),
		.trail_signal_fail_out(trail_signal_fail_out),
		.remote_defect_request(remote_defect_request),
		.remote_defect_detected(remote_defect_detected),
		.remote_defect_fault_report(remote_defect_fault_report),
		.server_fail_fault_report(server_fail_fault_report),
		.near_block_errored(near_block_errored), .national_use_bits(national_use_bits));
	pdhf_far_end far (.core_clk(core_clk), .line_data(line_data),
		.line_frame_start(line_frame_start), .line_bit_strobe(line_bit_strobe),
		.bit_clk(bit_clk), .tx_fs(tx_fs), .rx_fs(rx_fs), .rx_d(rx_d));
	// 50 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever
			#10 core_clk = ~core_clk;
	end
	// 600 ns tributary clock while trib_run, errored block pulse count
	always @(posedge core_clk)
	begin
		if (trib_run)
		begin
			trib_div <= (trib_div == 14) ? 0 : trib_div + 1;
			if (trib_div == 14)
				trib_clk <= ~trib_clk;
		end
		if (near_block_errored === 1'b1)
			nbe_cnt <= nbe_cnt + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// classic single bus cycle, read data left in rd
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		if (n >= 50)
			chk(32'h0000_0000, 32'h0000_0001);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic frame(input int len, input logic rdb, input logic [2:0] nub,
		input logic [11:0] err);
		far.send_frame(len, rdb, nub, err);
		repeat (12) @(posedge core_clk);
	endtask
	task automatic t_regs();
		wb(1'b0, pdhf_pkg::CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'(pdhf_pkg::CTRL_RESET));
		wb(1'b1, pdhf_pkg::NUB_OFS, 32'h0000_0005);
		wb(1'b0, pdhf_pkg::NUB_OFS, 32'h0000_0000);
		chk(rd & 32'h0000_0007, 32'h0000_0005);
		wb(1'b1, 8'h10, 32'hffff_ffff);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
	endtask
	task automatic t_trib();
		wb(1'b1, pdhf_pkg::CTRL_OFS, 32'h0000_0001);
		trib_run <= 1'b1;
		repeat (540) @(posedge core_clk);
		trib_run <= 1'b0;
		wb(1'b0, pdhf_pkg::STAT_OFS, 32'h0000_0000);
		chk(32'(rd[13:8]), 32'h0000_0012);
		trib_run <= 1'b1;
		frame(500, 1'b0, 3'h0, 12'h000);
		for (int k = 0; k < 118; k++)
		begin
			chk(32'(far.cap[16+4*k]), 32'h0000_0001);
			chk(32'(far.cap[17+4*k]), 32'h0000_0000);
		end
		chk(32'(far.cap[488]), 32'h0000_0000);
		trib_run <= 1'b0;
		// drain the store below half so the next frame justifies
		frame(112, 1'b0, 3'h0, 12'h000);
		frame(2448, 1'b0, 3'h0, 12'h000);
		for (int n = 0; n < 5; n++)
			chk(32'(far.cap[488+488*n]), 32'h0000_0001);
		chk(32'(far.cap[2444]), 32'h0000_0000);
		// fill the store with zeros so a wrongly driven unit shows
		trib_data <= 1'b0;
		trib_run <= 1'b1;
		repeat (1050) @(posedge core_clk);
		trib_run <= 1'b0;
		aggregate_in <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			wb(1'b1, pdhf_pkg::CTRL_OFS, 32'(m));
			access_permit <= (m == 0);
			frame(40, 1'b0, 3'h0, 12'h000);
			for (int p = 16; p < 40; p++)
				chk(32'(far.cap[p]), 32'h0000_0001);
		end
		aggregate_in <= 1'b0;
	endtask
	task automatic t_tx();
		wb(1'b1, pdhf_pkg::CTRL_OFS, 32'h0000_000a);
		for (int v = 1; v >= 0; v--)
		begin
			server_signal_fail_in <= v[0];
			repeat (3) @(posedge core_clk);
			chk(32'(trail_signal_fail_out), 32'(v));
			chk(32'(remote_defect_request), 32'(v));
			chk(32'(server_fail_fault_report), 32'(v));
			frame(32, 1'b0, 3'h0, 12'h000);
			for (int p = 0; p < 12; p++)
				chk(32'(far.cap[p]), 32'(pdhf_pkg::FAW_PATTERN[11-p]));
			chk(32'(far.cap[12]), 32'(v));
			chk({29'h0, far.cap[13], far.cap[14], far.cap[15]}, 32'h0000_0005);
		end
		server_signal_fail_in <= 1'b1;
		wb(1'b1, pdhf_pkg::CTRL_OFS, 32'h0000_0008);
		repeat (2) @(posedge core_clk);
		chk(32'(server_fail_fault_report), 32'h0000_0000);
		server_signal_fail_in <= 1'b0;
	endtask
	task automatic t_sink();
		int n0;
		wb(1'b1, pdhf_pkg::CTRL_OFS, 32'h0000_0006);
		repeat (6) frame(20, 1'b1, 3'h6, 12'h000);
		chk(32'(remote_defect_detected), 32'h0000_0001);
		chk(32'(remote_defect_fault_report), 32'h0000_0001);
		chk(32'(national_use_bits), 32'h0000_0006);
		wb(1'b1, pdhf_pkg::CTRL_OFS, 32'h0000_0004);
		repeat (2) @(posedge core_clk);
		chk(32'(remote_defect_fault_report), 32'h0000_0000);
		repeat (6) frame(20, 1'b0, 3'h1, 12'h000);
		chk(32'(remote_defect_detected), 32'h0000_0000);
		wb(1'b1, pdhf_pkg::ERRC_OFS, 32'h0000_0000);
		n0 = nbe_cnt;
		frame(20, 1'b0, 3'h1, 12'h001);
		frame(20, 1'b0, 3'h1, 12'h000);
		frame(20, 1'b0, 3'h1, 12'h800);
		wb(1'b0, pdhf_pkg::ERRC_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		chk(32'(nbe_cnt - n0), 32'h0000_0002);
	endtask
	task automatic end_sim();
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watchdog well beyond the expected run of about 0.6 ms
	initial
	begin
		#1_500_000;
		err_count++;
		end_sim();
	end
	// reset, then the scenarios
	initial
	begin
		rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, aggregate_in, server_signal_fail_in} = 5'h00;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0000_0000;
		{trib_clk, trib_run, access_permit, trib_data} = 4'h3;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_regs();
		t_trib();
		t_tx();
		t_sink();
		end_sim();
	end
endmodule // tb
`default_nettype wire
